// file: rtl/desc_attr_decode.sv
// Stage 1 descriptor decode of the protected attribute and the contiguous hint
`timescale 1ns/10ps
module desc_attr_decode import harden_pkg::*; #(
	parameter int PROT_BIT_128 = PROT_BIT_128_DEFAULT,
	parameter int CONTIG_BIT_128 = CONTIG_BIT_128_DEFAULT
) (
	input wire logic hardenOn,
	input wire logic format128,
	input wire logic protected_no_contig_ctrl,
	input wire logic [DESC_W-1:0] descLow,
	input wire logic [DESC_W-1:0] descHigh,
	output logic protectedAttr,
	output logic contigHint
);
	logic [2*DESC_W-1:0] desc128;

	assign desc128 = {descHigh, descLow};

	always_comb begin
		protectedAttr = 1'b0;
		contigHint = 1'b0;
		if (format128) begin
			// Wide format carries the protected attribute whenever hardening is implemented
			protectedAttr = hardenOn & desc128[PROT_BIT_128]; // R1 R13
			contigHint = desc128[CONTIG_BIT_128];
		end else if (hardenOn && protected_no_contig_ctrl) begin
			// Bit 52 moves over from contiguous hint to protected
			protectedAttr = descLow[PROT_BIT_64]; // R2
			contigHint = 1'b0; // R3
		end else begin
			// Legacy reading: no protected attribute, bit 52 is the hint
			protectedAttr = 1'b0; // R2 R13
			contigHint = descLow[CONTIG_BIT_64]; // R13
		end
	end
endmodule : desc_attr_decode

// file: rtl/harden_pkg.sv
// Constants shared by the translation hardening block and its descriptor decoder
package harden_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] OFS_ID = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_MASK = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_FAULT_COUNT = 8'h0C;
	localparam int ID_HARDEN_BIT = 0;
	localparam int EVT_W = 3;
	localparam int EVT_ASSURED_FAULT = 0;
	localparam int EVT_ATS_DENIED = 1;
	localparam int EVT_OTHER_FAULT = 2;
	localparam logic [EVT_W-1:0] STATUS_RESET = 3'h0;
	localparam logic [EVT_W-1:0] MASK_RESET = 3'h0;
	localparam int COUNT_W = 16;
	localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;
	localparam int DESC_W = 64;
	localparam int CONTIG_BIT_64 = 52;
	localparam int PROT_BIT_64 = 52;
	localparam int PROT_BIT_128_DEFAULT = 0;
	localparam int CONTIG_BIT_128_DEFAULT = 1;
endpackage : harden_pkg

// file: rtl/translation_hardening_checks.sv
// Translation hardening: descriptor attributes, assured-only check, registers and interrupt
`timescale 1ns/10ps
// Notes on behaviour
// [R1] Wide format always carries protected attribute
// [R2] Narrow format protected only with control set
// [R3] Control set: bit 52 not contiguous
// [R4] No read-check-write, no such checks
// [R5] Assured-only check enabled from stream entry
// [R6] Assured-only fault reported with indicator set
// [R7] Unassured descriptor fetch drops assured property
// [R8] Assured descriptor chain keeps normal property
// [R9] Stage 1 bypass into assured region faults
// [R10] Failed ATS request: success, no permissions
// [R11] Split-stage translated traffic ignores assured-only
// [R12] Assured-only check has highest fault priority
// [R13] Feature absent: legacy decode, no checks
module translation_hardening_checks import harden_pkg::*; #(
	parameter logic HARDENING_IMPL = 1'b1,
	parameter int PROT_BIT_128 = PROT_BIT_128_DEFAULT,
	parameter int CONTIG_BIT_128 = CONTIG_BIT_128_DEFAULT
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [DATA_W-1:0] regWrData,
	input wire logic regWrEn,
	input wire logic regRdEn,
	output logic [DATA_W-1:0] regRdData,
	output logic irq,
	input wire logic reqValid,
	input wire logic reqAtsRequest,
	input wire logic reqAtsTranslated,
	input wire logic reqSplitStageAts,
	input wire logic reqStage1Bypass,
	input wire logic reqTableWalk,
	input wire logic reqSteAssuredOnlyEn,
	input wire logic reqRegionAssuredOnly,
	input wire logic reqCdFetchAssured,
	input wire logic reqL1cdFetchAssured,
	input wire logic reqArchAssured,
	input wire logic reqOtherS2Fault,
	input wire logic reqPermRead,
	input wire logic reqPermWrite,
	input wire logic reqFormat128,
	input wire logic protected_no_contig_ctrl,
	input wire logic [DESC_W-1:0] reqDescLow,
	input wire logic [DESC_W-1:0] reqDescHigh,
	output logic rspValid,
	output logic rspProtected,
	output logic rspContig,
	output logic rspAssuredTranslation,
	output logic rspPermitted,
	output logic atsCompletion,
	output logic atsSuccess,
	output logic atsRead,
	output logic atsWrite,
	output logic faultEvent,
	output logic faultStage2,
	output logic faultAssuredOnly,
	output logic faultOnWalk
);
	logic hardenOn;
	logic protDec;
	logic contigDec;
	logic assuredEnable;
	logic splitIgnore;
	logic chainAssured;
	logic assuredProp;
	logic assuredFail;
	logic anyFault;
	logic isAts;
	logic [EVT_W-1:0] eventHit;
	logic [EVT_W-1:0] status_reg;
	logic [EVT_W-1:0] mask_reg;
	logic [COUNT_W-1:0] faultCount_reg;
	logic [DATA_W-1:0] rdData_reg;
	logic [DATA_W-1:0] rdData_next;

	assign hardenOn = HARDENING_IMPL;

	desc_attr_decode #(
		.PROT_BIT_128(PROT_BIT_128),
		.CONTIG_BIT_128(CONTIG_BIT_128)
	) u_decode (
		.hardenOn(hardenOn),
		.format128(reqFormat128),
		.protected_no_contig_ctrl(protected_no_contig_ctrl),
		.descLow(reqDescLow),
		.descHigh(reqDescHigh),
		.protectedAttr(protDec),
		.contigHint(contigDec)
	);

	// Check enable comes only from the stream entry field
	assign assuredEnable = hardenOn & reqSteAssuredOnlyEn; // R5 R13
	// Translated traffic under split-stage ATS skips the check
	assign splitIgnore = reqAtsTranslated & reqSplitStageAts; // R11
	// Both the descriptor and its pointer must come from assured memory
	assign chainAssured = reqCdFetchAssured & reqL1cdFetchAssured; // R7 R8
	// Bypassed stage 1 never carries the assured property
	assign assuredProp = hardenOn & ~reqStage1Bypass & chainAssured & reqArchAssured; // R7 R8 R9
	// Table walk addresses are checked too; no read-check-write path exists
	assign assuredFail = assuredEnable & reqRegionAssuredOnly & ~assuredProp & ~splitIgnore; // R4 R9 R12
	assign anyFault = assuredFail | reqOtherS2Fault;
	assign isAts = reqAtsRequest;

	// Response and fault outputs, one cycle after the request
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rspValid <= 1'b0;
			rspProtected <= 1'b0;
			rspContig <= 1'b0;
			rspAssuredTranslation <= 1'b0;
			rspPermitted <= 1'b0;
		end else begin
			rspValid <= reqValid & ~isAts;
			rspProtected <= reqValid & protDec; // R1 R2
			rspContig <= reqValid & contigDec; // R3
			rspAssuredTranslation <= reqValid & assuredProp; // R7 R8
			rspPermitted <= reqValid & ~isAts & ~anyFault;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			atsCompletion <= 1'b0;
			atsSuccess <= 1'b0;
			atsRead <= 1'b0;
			atsWrite <= 1'b0;
		end else begin
			atsCompletion <= reqValid & isAts;
			// A failed check still completes with success
			atsSuccess <= reqValid & isAts & ~reqOtherS2Fault; // R10
			atsRead <= reqValid & isAts & reqPermRead & ~anyFault; // R10
			atsWrite <= reqValid & isAts & reqPermWrite & ~anyFault; // R10
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			faultEvent <= 1'b0;
			faultStage2 <= 1'b0;
			faultAssuredOnly <= 1'b0;
			faultOnWalk <= 1'b0;
		end else begin
			faultEvent <= reqValid & ~isAts & anyFault; // R6
			faultStage2 <= reqValid & ~isAts & anyFault; // R6
			// The assured-only cause outranks every other stage 2 cause
			faultAssuredOnly <= reqValid & ~isAts & assuredFail; // R6 R12
			faultOnWalk <= reqValid & ~isAts & anyFault & reqTableWalk; // R12
		end
	end

	assign eventHit[EVT_ASSURED_FAULT] = reqValid & ~isAts & assuredFail;
	assign eventHit[EVT_ATS_DENIED] = reqValid & isAts & assuredFail;
	assign eventHit[EVT_OTHER_FAULT] = reqValid & ~isAts & reqOtherS2Fault & ~assuredFail;

	// Sticky status, write one to clear; a new event beats the clear
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			status_reg <= STATUS_RESET;
		end else begin
			if (regWrEn && regAddr == OFS_STATUS) begin
				status_reg <= (status_reg & ~regWrData[EVT_W-1:0]) | eventHit;
			end else begin
				status_reg <= status_reg | eventHit;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mask_reg <= MASK_RESET;
		end else if (regWrEn && regAddr == OFS_MASK) begin
			mask_reg <= regWrData[EVT_W-1:0];
		end
	end

	// Saturating count of assured-only faults
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			faultCount_reg <= COUNT_RESET;
		end else if (eventHit[EVT_ASSURED_FAULT] && faultCount_reg != {COUNT_W{1'b1}}) begin
			faultCount_reg <= faultCount_reg + 1'b1;
		end
	end

	assign irq = |(status_reg & mask_reg);

	always_comb begin
		rdData_next = RD_ZERO;
		if (regRdEn) begin
			unique case (regAddr)
				OFS_ID: rdData_next[ID_HARDEN_BIT] = hardenOn;
				OFS_STATUS: rdData_next[EVT_W-1:0] = status_reg;
				OFS_MASK: rdData_next[EVT_W-1:0] = mask_reg;
				OFS_FAULT_COUNT: rdData_next[COUNT_W-1:0] = faultCount_reg;
				default: rdData_next = RD_ZERO;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdData_reg <= RD_ZERO;
		end else begin
			rdData_reg <= rdData_next;
		end
	end

	assign regRdData = rdData_reg;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	logic [DESC_W-1:0] pastDescLow;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pastDescLow <= {DESC_W{1'b0}};
		end else begin
			pastDescLow <= reqDescLow;
		end
	end

	// Whole wide descriptor, so the checks can index it directly
	logic [2*DESC_W-1:0] descWide;
	assign descWide = {reqDescHigh, reqDescLow};

	wide_always_protected_a: assert property ( // R1
		reqValid && reqFormat128 && hardenOn && descWide[PROT_BIT_128] |=> rspProtected)
		else $error("wide descriptor lost protected attribute");

	wide_unprotected_a: assert property ( // R1
		reqValid && reqFormat128 && !descWide[PROT_BIT_128] |=> !rspProtected)
		else $error("wide descriptor protected without the attribute bit");

	narrow_protected_a: assert property ( // R2
		reqValid && !reqFormat128 |=> rspProtected == (hardenOn && $past(protected_no_contig_ctrl)
		&& pastDescLow[PROT_BIT_64]))
		else $error("narrow protected attribute decoded wrongly");

	no_contig_hint_a: assert property ( // R3
		reqValid && !reqFormat128 && hardenOn && protected_no_contig_ctrl |=> !rspContig)
		else $error("bit 52 taken as contiguous hint under control");

	assured_enable_src_a: assert property ( // R5
		reqValid && !reqSteAssuredOnlyEn && !reqOtherS2Fault && !reqAtsRequest |=> !faultEvent)
		else $error("assured fault without stream entry enable");

	assured_fault_report_a: assert property ( // R6
		reqValid && !reqAtsRequest && assuredFail |=> faultEvent && faultStage2 && faultAssuredOnly)
		else $error("assured fault not reported with indicator");

	unassured_chain_a: assert property ( // R7
		reqValid && !(reqCdFetchAssured && reqL1cdFetchAssured) |=> !rspAssuredTranslation)
		else $error("assured property kept after unassured fetch");

	assured_chain_a: assert property ( // R8
		reqValid && hardenOn && reqCdFetchAssured && reqL1cdFetchAssured && reqArchAssured
		&& !reqStage1Bypass |=> rspAssuredTranslation)
		else $error("assured chain lost its property");

	bypass_fault_a: assert property ( // R9
		reqValid && !reqAtsRequest && assuredEnable && reqStage1Bypass && reqRegionAssuredOnly
		&& !splitIgnore |=> faultAssuredOnly && status_reg[EVT_ASSURED_FAULT])
		else $error("bypassed access to assured region not faulted");

	ats_denied_a: assert property ( // R10
		reqValid && reqAtsRequest && assuredFail && !reqOtherS2Fault
		|=> atsCompletion && atsSuccess && !atsRead && !atsWrite && !faultEvent)
		else $error("failed ATS request completion wrong");

	split_ignore_a: assert property ( // R11
		reqValid && reqAtsTranslated && reqSplitStageAts |=> !faultAssuredOnly)
		else $error("split-stage translated traffic checked for assured");

	priority_walk_a: assert property ( // R12
		reqValid && !reqAtsRequest && assuredFail && reqOtherS2Fault && reqTableWalk
		|=> faultAssuredOnly && faultOnWalk)
		else $error("assured cause not first on walk fault");

	legacy_mode_a: assert property ( // R13
		!hardenOn && reqValid |=> !rspProtected && !faultAssuredOnly && !rspAssuredTranslation)
		else $error("hardening effects without the feature");

	irq_level_a: assert property (
		|(status_reg & mask_reg) |-> irq)
		else $error("interrupt low with unmasked status");

	read_one_cycle_a: assert property (
		!regRdEn |=> regRdData == RD_ZERO)
		else $error("read data outside its cycle");

	ats_no_event_a: assert property ( // R10
		reqValid && reqAtsRequest |=> !rspValid && !faultEvent && !faultAssuredOnly)
		else $error("ATS request answered as a transaction");

	ats_denied_status_a: assert property ( // R10
		reqValid && reqAtsRequest && assuredFail |=> status_reg[EVT_ATS_DENIED])
		else $error("ATS denial not recorded in status");

	denied_not_permitted_a: assert property ( // R6
		reqValid && !reqAtsRequest && assuredFail |=> rspValid && !rspPermitted)
		else $error("assured-only failure still permitted");

	other_fault_only_a: assert property ( // R12
		reqValid && !reqAtsRequest && reqOtherS2Fault && !assuredFail
		|=> faultEvent && faultStage2 && !faultAssuredOnly)
		else $error("other stage 2 fault reported wrongly");

	walk_flag_a: assert property ( // R12
		reqValid && !reqTableWalk |=> !faultOnWalk)
		else $error("walk flag without table walk access");

	idle_quiet_a: assert property (
		!reqValid |=> !rspValid && !atsCompletion && !faultEvent)
		else $error("answer without a request");

	status_set_wins_a: assert property (
		eventHit[EVT_ASSURED_FAULT] |=> status_reg[EVT_ASSURED_FAULT])
		else $error("status event lost");

	status_clear_a: assert property (
		regWrEn && regAddr == OFS_STATUS && regWrData[EVT_ASSURED_FAULT] && !eventHit[EVT_ASSURED_FAULT]
		|=> !status_reg[EVT_ASSURED_FAULT])
		else $error("status bit not cleared by writing one");

	mask_write_a: assert property (
		regWrEn && regAddr == OFS_MASK |=> mask_reg == $past(regWrData[EVT_W-1:0]))
		else $error("mask write not taken");

	mask_hold_a: assert property (
		!(regWrEn && regAddr == OFS_MASK) |=> $stable(mask_reg))
		else $error("mask changed without a write");

	count_step_a: assert property (
		eventHit[EVT_ASSURED_FAULT] && faultCount_reg != {COUNT_W{1'b1}}
		|=> faultCount_reg == $past(faultCount_reg) + 1'b1)
		else $error("fault count did not step");

	count_hold_a: assert property (
		!eventHit[EVT_ASSURED_FAULT] |=> $stable(faultCount_reg))
		else $error("fault count changed without an event");

	read_status_a: assert property (
		regRdEn && regAddr == OFS_STATUS |=> regRdData[EVT_W-1:0] == $past(status_reg))
		else $error("status read back wrongly");

	bypass_fault_c: cover property (reqValid && reqStage1Bypass && assuredFail);
	ats_denied_c: cover property (reqValid && reqAtsRequest && assuredFail);
	split_skip_c: cover property (reqValid && splitIgnore && reqRegionAssuredOnly && assuredEnable);
	irq_raise_c: cover property (!irq ##1 irq);
	wide_format_c: cover property (reqValid && reqFormat128 && protDec);
endmodule : translation_hardening_checks

// file: verification/testbench.sv
// Self-checking bench for the translation hardening block
`timescale 1ns/10ps
module testbench;
	import harden_pkg::*;
	logic ref_clk, rst_n, regWrEn, regRdEn, irq, reqValid;
	logic [ADDR_W-1:0] regAddr;
	logic [DATA_W-1:0] regWrData, regRdData;
	logic [14:0] f;
	logic [DESC_W-1:0] lo, hi;
	wire [8:0] rsp;
	wire [3:0] ats;
	wire [8:0] rspLegacy;
	wire [3:0] atsLegacy;
	wire [DATA_W-1:0] rdLegacy;
	int mismatches, n_compared;
	logic [31:0] seed;
	logic [14:0] corner [8] = '{15'h0BE0, 15'h430C, 15'h3300, 15'h00E0, 15'h00A0, 15'h0001, 15'h0700, 15'h0310};
	upstream_requester req (.ref_clk(ref_clk), .reqValid(reqValid), .reqFlags(f), .reqDescLow(lo), .reqDescHigh(hi));
	translation_hardening_checks dut (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
		.regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .irq(irq), .reqValid(reqValid),
		.reqAtsRequest(f[14]), .reqAtsTranslated(f[13]), .reqSplitStageAts(f[12]), .reqStage1Bypass(f[11]),
		.reqTableWalk(f[10]), .reqSteAssuredOnlyEn(f[9]), .reqRegionAssuredOnly(f[8]), .reqCdFetchAssured(f[7]),
		.reqL1cdFetchAssured(f[6]), .reqArchAssured(f[5]), .reqOtherS2Fault(f[4]), .reqPermRead(f[3]),
		.reqPermWrite(f[2]), .reqFormat128(f[1]), .protected_no_contig_ctrl(f[0]), .reqDescLow(lo),
		.reqDescHigh(hi), .rspValid(rsp[8]), .rspProtected(rsp[7]), .rspContig(rsp[6]),
		.rspAssuredTranslation(rsp[5]), .rspPermitted(rsp[4]), .atsCompletion(ats[3]), .atsSuccess(ats[2]),
		.atsRead(ats[1]), .atsWrite(ats[0]), .faultEvent(rsp[3]), .faultStage2(rsp[2]),
		.faultAssuredOnly(rsp[1]), .faultOnWalk(rsp[0]));
	translation_hardening_checks #(.HARDENING_IMPL(1'b0)) dutLegacy (.ref_clk(ref_clk), .rst_n(rst_n),
		.regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(rdLegacy), .irq(),
		.reqValid(reqValid), .reqAtsRequest(f[14]), .reqAtsTranslated(f[13]), .reqSplitStageAts(f[12]),
		.reqStage1Bypass(f[11]), .reqTableWalk(f[10]), .reqSteAssuredOnlyEn(f[9]), .reqRegionAssuredOnly(f[8]),
		.reqCdFetchAssured(f[7]), .reqL1cdFetchAssured(f[6]), .reqArchAssured(f[5]), .reqOtherS2Fault(f[4]),
		.reqPermRead(f[3]), .reqPermWrite(f[2]), .reqFormat128(f[1]), .protected_no_contig_ctrl(f[0]), .reqDescLow(lo),
		.reqDescHigh(hi), .rspValid(rspLegacy[8]), .rspProtected(rspLegacy[7]), .rspContig(rspLegacy[6]),
		.rspAssuredTranslation(rspLegacy[5]), .rspPermitted(rspLegacy[4]), .atsCompletion(atsLegacy[3]),
		.atsSuccess(atsLegacy[2]), .atsRead(atsLegacy[1]), .atsWrite(atsLegacy[0]), .faultEvent(rspLegacy[3]),
		.faultStage2(rspLegacy[2]), .faultAssuredOnly(rspLegacy[1]), .faultOnWalk(rspLegacy[0]));
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], 1'b0} ^ (x[31] ? 32'h0040_0007 : 32'h0000_0000);
	endfunction : lfsr
	function automatic logic prop(input logic [14:0] q, input logic hardOn);
		return hardOn && !q[11] && q[7] && q[6] && q[5];
	endfunction : prop
	function automatic logic fail(input logic [14:0] q, input logic hardOn);
		return hardOn && q[9] && q[8] && !prop(q, hardOn) && !(q[13] && q[12]);
	endfunction : fail
	function automatic logic [8:0] expRsp(input logic [14:0] q, input logic [127:0] d, input logic hardOn);
		logic flt, prt, ctg;
		flt = fail(q, hardOn) | q[4];
		prt = hardOn & (q[1] ? d[PROT_BIT_128_DEFAULT] : (q[0] & d[PROT_BIT_64]));
		ctg = q[1] ? d[CONTIG_BIT_128_DEFAULT] : (!(hardOn & q[0]) & d[CONTIG_BIT_64]);
		return {1'b1, prt, ctg, prop(q, hardOn), !flt, flt, flt, fail(q, hardOn), flt & q[10]};
	endfunction : expRsp
	function automatic logic [5:0] expAts(input logic [14:0] q, input logic hardOn);
		logic flt;
		flt = fail(q, hardOn) | q[4];
		return {1'b1, !q[4], q[3] & !flt, q[2] & !flt, 2'h0};
	endfunction : expAts
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic send(input logic [14:0] q, input logic [63:0] l, input logic [63:0] h);
		req.issue(q, l, h);
		#1;
		if (q[14]) begin
			check({ats, rsp[8], rsp[3]}, expAts(q, 1'b1));
			check({atsLegacy, rspLegacy[8], rspLegacy[3]}, expAts(q, 1'b0));
		end else begin
			check({ats, rsp}, {4'h0, expRsp(q, {h, l}, 1'b1)});
			check({atsLegacy, rspLegacy}, {4'h0, expRsp(q, {h, l}, 1'b0)});
		end
	endtask : send
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWrData <= d;
		regWrEn <= 1'b1;
		@(posedge ref_clk);
		regWrEn <= 1'b0;
	endtask : wr
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		@(posedge ref_clk);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge ref_clk);
		regRdEn <= 1'b0;
		#1 check(regRdData, e);
	endtask : rd
	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : results
	initial begin
		repeat (50000) @(posedge ref_clk);
		mismatches++;
		results();
	end
	initial begin
		regWrEn = 1'b0;
		regRdEn = 1'b0;
		regAddr = '0;
		regWrData = '0;
		rst_n = 1'b0;
		mismatches = 0;
		n_compared = 0;
		seed = 32'h6808_f965;
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
		rd(OFS_ID, 32'h0000_0001);
		check(rdLegacy, RD_ZERO);
		rd(OFS_STATUS, RD_ZERO);
		rd(OFS_MASK, RD_ZERO);
		rd(OFS_FAULT_COUNT, RD_ZERO);
		rd(8'h10, RD_ZERO);
		wr(OFS_ID, 32'h0000_0000);
		rd(OFS_ID, 32'h0000_0001);
		wr(OFS_MASK, 32'h0000_0001);
		// Stage 1 bypass into an assured-only region raises the event and interrupt
		send(corner[0], 64'h0010_0000_0000_0000, '0);
		@(posedge ref_clk);
		#1 check(irq, 1'b1);
		rd(OFS_STATUS, 32'h0000_0001);
		rd(OFS_FAULT_COUNT, 32'h0000_0001);
		wr(OFS_STATUS, 32'h0000_0001);
		rd(OFS_STATUS, RD_ZERO);
		#1 check(irq, 1'b0);
		wr(OFS_MASK, 32'h0000_0000);
		for (int i = 0; i < 8; i++) begin
			send(corner[i], 64'h0010_0000_0000_0000, 64'h0000_0000_0000_0003);
			send(corner[i] | 15'h0002, 64'h0000_0000_0000_0001, '0);
		end
		repeat (300) begin
			seed = lfsr(seed);
			send(seed[14:0], {seed, lfsr(seed)}, {lfsr(seed), seed});
		end
		// Reset in mid-run clears the sticky status and the fault count
		rst_n <= 1'b0;
		@(posedge ref_clk);
		rst_n <= 1'b1;
		rd(OFS_STATUS, RD_ZERO);
		rd(OFS_FAULT_COUNT, RD_ZERO);
		results();
	end
endmodule : testbench

// file: verification/upstream_requester.sv
// Upstream requester model issuing one translation request per call
`timescale 1ns/10ps
module upstream_requester (
	input wire logic ref_clk,
	output logic reqValid,
	output logic [14:0] reqFlags,
	output logic [63:0] reqDescLow,
	output logic [63:0] reqDescHigh
);
	initial begin
		reqValid = 1'b0;
		reqFlags = 15'h0000;
		reqDescLow = '0;
		reqDescHigh = '0;
	end
	// Fields are inverted after release so a stale value is never mistaken for a held one
	task automatic issue(input logic [14:0] f, input logic [63:0] lo, input logic [63:0] hi);
		@(posedge ref_clk);
		reqValid <= 1'b1;
		reqFlags <= f;
		reqDescLow <= lo;
		reqDescHigh <= hi;
		@(posedge ref_clk);
		reqValid <= 1'b0;
		reqFlags <= ~f;
		reqDescLow <= ~lo;
		reqDescHigh <= ~hi;
	endtask : issue
endmodule : upstream_requester
